// ==== pkg/pis_pkg.sv ====
package pis_pkg;

    // Command field codes latched from the low four bits of the address word.
    localparam logic [3:0] CMD_READ1 = 4'h0;
    localparam logic [3:0] CMD_READ2 = 4'h8;
    localparam logic [3:0] CMD_WRITE1 = 4'h1;
    localparam logic [3:0] CMD_WRITE2 = 4'h9;
    localparam logic [3:0] CMD_SKIP1 = 4'h2;
    localparam logic [3:0] CMD_SKIP2 = 4'h3;
    localparam logic [3:0] CMD_SKIP3 = 4'ha;
    localparam logic [3:0] CMD_SKIP4 = 4'hb;
    localparam logic [3:0] CMD_RD_CTRL_A = 4'h4;
    localparam logic [3:0] CMD_WR_CTRL_A = 4'h5;
    localparam logic [3:0] CMD_WR_CTRL_B = 4'hd;
    localparam logic [3:0] CMD_WR_VECTOR = 4'hc;
    localparam logic [3:0] CMD_SET_FLAG1 = 4'h6;
    localparam logic [3:0] CMD_SET_FLAG3 = 4'he;
    localparam logic [3:0] CMD_CLR_FLAG1 = 4'h7;
    localparam logic [3:0] CMD_CLR_FLAG3 = 4'hf;

    // Field positions inside control A, control B and the vector word.
    localparam int CRA_FLAG_LSB = 0;
    localparam int CRA_IE_LSB = 4;
    localparam int CRA_WP_LSB = 8;
    localparam int CRB_LEVEL_LSB = 0;
    localparam int CRB_POL_LSB = 4;
    localparam int VEC_BASE_BITS = 10;
    localparam int DATA_BITS = 12;
    localparam int SENSE_COUNT = 4;
    localparam int FLAG1_IDX = 0;
    localparam int FLAG3_IDX = 2;

    // Reset values of the programmable registers.
    localparam logic [3:0] FLAG_RESET = 4'h0;
    localparam logic [3:0] IE_RESET = 4'h0;
    localparam logic [1:0] WP_RESET = 2'h0;
    localparam logic [3:0] LEVEL_RESET = 4'h0;
    localparam logic [3:0] POL_RESET = 4'h0;
    localparam logic [9:0] VEC_RESET = 10'h000;

    // Processor timing signals, all sampled on the block clock.
    typedef struct packed {
        logic loadAddressPulse;
        logic deviceSelectN;
        logic readWriteTiming;
        logic ioInstruction;
        logic ioExecutePhase;
    } pis_cpu_t;

    // Control A contents.
    typedef struct packed {
        logic [1:0] writePolarity;
        logic [3:0] irqEnableBits;
        logic [3:0] flagBits;
    } pis_ctrl_a_t;

    // Control B contents.
    typedef struct packed {
        logic [3:0] sensePolaritySelect;
        logic [3:0] senseLevelSelect;
    } pis_ctrl_b_t;

    // Transfer phase tracker, one-hot.
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_READ = 4'h2,
        ST_WRITE = 4'h4,
        ST_VECTOR = 4'h8
    } pis_state_t;

endpackage

// ==== hw/pis_sense_cell.sv ====
`timescale 1ns/1ns
module pis_sense_cell
    import pis_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic senseIn,
    input wire logic levelMode,
    input wire logic polarity,
    input wire logic irqEnable,
    input wire logic clearPair,
    input wire logic clearIrq,
    input wire logic clearAll,
    output logic skipFlag,
    output logic irqFlag
);
    logic senseLast_reg;
    logic skip_reg;
    logic irq_reg;
    logic skip_next;
    logic irq_next;
    wire logic activeNow;
    wire logic activeLast;
    wire logic activeEdge;
    wire logic setSkip;
    wire logic setIrq;

    // Polarity folds both edge kinds and both levels into one test.
    assign activeNow = polarity ? senseIn : ~senseIn;
    assign activeLast = polarity ? senseLast_reg : ~senseLast_reg;
    assign activeEdge = activeNow & ~activeLast;
    assign setSkip = levelMode ? activeNow : activeEdge;
    // Only edges may raise the interrupt flop; a level never does.
    assign setIrq = ~levelMode & activeEdge & irqEnable;

    // A new set wins over a clear in the same cycle, so no event is lost.
    assign skip_next = setSkip | (skip_reg & ~(clearPair | clearAll));
    // A cleared enable holds the interrupt flop in reset.
    assign irq_next = irqEnable &
        (setIrq | (irq_reg & ~(clearPair | clearIrq | clearAll)));

    // Sense history and the two flops of this input.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            senseLast_reg <= 1'b0;
            skip_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            senseLast_reg <= senseIn;
            skip_reg <= skip_next;
            irq_reg <= irq_next;
        end
    end

    assign skipFlag = skip_reg;
    assign irqFlag = irq_reg;

endmodule

// ==== hw/pis_parallel_io.sv ====
`timescale 1ns/1ns
// What this block does
// - Read command pulses active-low peripheral read strobe
// - Write strobe pulse polarity follows write-polarity bit
// - Type and skip lines only ever pull low
// - Type lines encode write, OR-read, vector, skip
// - Enabled sense flops pull line low during load pulse
// - Skip pulls line low in read window if set
// - Control A is readable and writable
// - Flag outputs follow control A flag bits
// - Enable bit gates interrupts, else skip only
// - Control B is write only
// - Level bit one means level, zero edge
// - Only enabled edge events request interrupts
// - Polarity bit picks high/rising or low/falling
// - Grant high freezes requests and chain, enables vector
// - Selected only with chain input high and request
// - Sense one highest priority, sense four lowest
// - Vector is ten base bits plus code
// - Chain input low gives no vector
// - Clear-all, skip pair, vector winner, disabled hold
// - Control A read drives bus in read phase
// - Register writes capture bus in write phase
module pis_parallel_io
    import pis_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire pis_cpu_t cpu,
    input wire logic addressMatch,
    input wire logic clearAllFlagsCmd,
    input wire logic irqGrant,
    input wire logic priorityChainIn,
    output logic priorityChainOut,
    input wire logic [DATA_BITS-1:0] dxIn,
    output logic [DATA_BITS-1:0] dxOut,
    output logic dxOe,
    input wire logic [SENSE_COUNT-1:0] sense,
    output logic [3:0] flagBits,
    output logic [1:0] readStrobeN,
    output logic [1:0] writeStrobe,
    input wire logic transferTypeANIn,
    output logic transferTypeANOut,
    output logic transferTypeANOe,
    input wire logic transferTypeBNIn,
    output logic transferTypeBNOut,
    output logic transferTypeBNOe,
    input wire logic skipOrIrqNIn,
    output logic skipOrIrqNOut,
    output logic skipOrIrqNOe
);
    pis_state_t state_reg;
    pis_state_t state_next;
    pis_ctrl_a_t controlA_reg;
    pis_ctrl_b_t controlB_reg;
    logic [VEC_BASE_BITS-1:0] vectorBase_reg;
    logic [3:0] command_reg;
    logic commandValid_reg;
    logic [SENSE_COUNT-1:0] pending_reg;
    logic [DATA_BITS-1:0] dxOut_reg;
    logic dxOe_reg;
    logic [1:0] readStrobeN_reg;
    logic [1:0] writeStrobe_reg;
    logic [SENSE_COUNT-1:0] skipFlags;
    logic [SENSE_COUNT-1:0] irqFlags;

    // Lowest index wins: sense one outranks sense four.
    function automatic logic [3:0] winner(input logic [3:0] req);
        logic [3:0] hit;
        hit = 4'h0;
        if (req[0]) begin
            hit = 4'h1;
        end else if (req[1]) begin
            hit = 4'h2;
        end else if (req[2]) begin
            hit = 4'h4;
        end else if (req[3]) begin
            hit = 4'h8;
        end
        return hit;
    endfunction

    // Two-bit source code of a one-hot winner.
    function automatic logic [1:0] encode(input logic [3:0] hot);
        return {hot[3] | hot[2], hot[3] | hot[1]};
    endfunction

    // Command decode of the latched control field.
    wire logic isRead1 = command_reg == CMD_READ1;
    wire logic isRead2 = command_reg == CMD_READ2;
    wire logic isWrite1 = command_reg == CMD_WRITE1;
    wire logic isWrite2 = command_reg == CMD_WRITE2;
    wire logic isReadA = command_reg == CMD_RD_CTRL_A;
    wire logic isWriteA = command_reg == CMD_WR_CTRL_A;
    wire logic isWriteB = command_reg == CMD_WR_CTRL_B;
    wire logic isWriteV = command_reg == CMD_WR_VECTOR;
    wire logic isSkip = command_reg == CMD_SKIP1 ||
        command_reg == CMD_SKIP2 || command_reg == CMD_SKIP3 ||
        command_reg == CMD_SKIP4;
    // Skip selector: bit 0 picks the even sense (two or four), bit 3 picks the upper pair.
    wire logic [1:0] skipIndex = {command_reg[3], command_reg[0]};
    wire logic [3:0] skipHot = 4'h1 << skipIndex;

    // Processor phases; device select low opens an execute window.
    wire logic execWin = cpu.ioExecutePhase & ~cpu.deviceSelectN;
    wire logic readWin = execWin & cpu.readWriteTiming;
    wire logic writeWin = execWin & ~cpu.readWriteTiming;
    wire logic ourCmd = commandValid_reg & ~irqGrant;

    // Grant freezes the chain on the snapshot taken before it rose.
    wire logic anyPending = |pending_reg;
    wire logic selected = priorityChainIn & anyPending;
    wire logic [3:0] winHot = winner(pending_reg);
    wire logic [DATA_BITS-1:0] vectorWord =
        {encode(winHot), vectorBase_reg};
    wire logic vectorWin = irqGrant & selected & readWin;

    // Interrupt request only while the load pulse is high, never in grant.
    wire logic irqPull =
        cpu.loadAddressPulse & ~irqGrant & (|irqFlags);
    wire logic skipPull = state_reg == ST_READ & isSkip &
        |(skipFlags & skipHot);

    // Clears taken when a window closes.
    wire logic readDone = state_reg == ST_READ & ~readWin;
    wire logic vectorDone = state_reg == ST_VECTOR & ~readWin;
    wire logic [3:0] clearPair = (readDone & isSkip) ? skipHot : 4'h0;
    wire logic [3:0] clearIrq = vectorDone ? winHot : 4'h0;

    // One sense cell per input; the cells own the skip and interrupt flops.
    genvar g;
    generate
        for (g = 0; g < SENSE_COUNT; g++) begin : g_sense
            pis_sense_cell u_cell (
                .clock(clock),
                .nrst(nrst),
                .senseIn(sense[g]),
                .levelMode(controlB_reg.senseLevelSelect[g]),
                .polarity(controlB_reg.sensePolaritySelect[g]),
                .irqEnable(controlA_reg.irqEnableBits[g]),
                .clearPair(clearPair[g]),
                .clearIrq(clearIrq[g]),
                .clearAll(clearAllFlagsCmd),
                .skipFlag(skipFlags[g]),
                .irqFlag(irqFlags[g])
            );
        end
    endgenerate

    // Phase tracker: a window opens on select and closes when it drops.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (vectorWin) begin
                    state_next = ST_VECTOR;
                end else if (readWin & ourCmd) begin
                    state_next = ST_READ;
                end else if (writeWin & ourCmd) begin
                    state_next = ST_WRITE;
                end
            end
            ST_READ: begin
                if (!readWin) begin
                    state_next = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (!writeWin) begin
                    state_next = ST_IDLE;
                end
            end
            ST_VECTOR: begin
                if (!readWin) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    wire logic writeStart = state_reg == ST_IDLE & state_next == ST_WRITE;
    wire logic readStart = state_reg == ST_IDLE & state_next == ST_READ;
    wire logic opDone = (state_reg != ST_IDLE) & (state_next == ST_IDLE);

    // Command latch: the address word is taken on the load pulse.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            command_reg <= 4'h0;
            commandValid_reg <= 1'b0;
        end else if (cpu.loadAddressPulse) begin
            command_reg <= dxIn[3:0];
            commandValid_reg <= cpu.ioInstruction & addressMatch;
        end else if (opDone) begin
            commandValid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Snapshot of interrupt flops; frozen while grant is high.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pending_reg <= 4'h0;
        end else if (!irqGrant && cpu.loadAddressPulse) begin
            pending_reg <= irqFlags;
        end else if (vectorDone) begin
            pending_reg <= pending_reg & ~winHot;
        end
    end

    // Register writes land at the start of the write window.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            controlA_reg <= '{WP_RESET, IE_RESET, FLAG_RESET};
            controlB_reg <= '{POL_RESET, LEVEL_RESET};
            vectorBase_reg <= VEC_RESET;
        end else if (writeStart && isWriteA) begin
            controlA_reg.flagBits <= dxIn[CRA_FLAG_LSB +: 4];
            controlA_reg.irqEnableBits <= dxIn[CRA_IE_LSB +: 4];
            controlA_reg.writePolarity <= dxIn[CRA_WP_LSB +: 2];
        end else if (writeStart && isWriteB) begin
            controlB_reg.senseLevelSelect <= dxIn[CRB_LEVEL_LSB +: 4];
            controlB_reg.sensePolaritySelect <= dxIn[CRB_POL_LSB +: 4];
        end else if (writeStart && isWriteV) begin
            vectorBase_reg <= dxIn[VEC_BASE_BITS-1:0];
        end else if (readStart || writeStart) begin
            if (command_reg == CMD_SET_FLAG1) begin
                controlA_reg.flagBits[FLAG1_IDX] <= 1'b1;
            end else if (command_reg == CMD_SET_FLAG3) begin
                controlA_reg.flagBits[FLAG3_IDX] <= 1'b1;
            end else if (command_reg == CMD_CLR_FLAG1) begin
                controlA_reg.flagBits[FLAG1_IDX] <= 1'b0;
            end else if (command_reg == CMD_CLR_FLAG3) begin
                controlA_reg.flagBits[FLAG3_IDX] <= 1'b0;
            end
        end
    end

    // Bus drive: control A readback or the vector, else released.
    wire logic [DATA_BITS-1:0] controlAWord =
        {2'h0, controlA_reg.writePolarity, controlA_reg.irqEnableBits,
        controlA_reg.flagBits};
    wire logic driveA = state_next == ST_READ & isReadA;
    wire logic driveV = state_next == ST_VECTOR;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dxOut_reg <= 12'h000;
            dxOe_reg <= 1'b0;
        end else begin
            dxOut_reg <= driveV ? vectorWord :
                (driveA ? controlAWord : 12'h000);
            dxOe_reg <= driveV | driveA;
        end
    end

    // Peripheral strobes; write idle level is the inverse of its polarity.
    wire logic [1:0] readHit = {isRead2, isRead1} & {2{state_next == ST_READ}};
    wire logic [1:0] writeHit =
        {isWrite2, isWrite1} & {2{state_next == ST_WRITE}};
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            readStrobeN_reg <= 2'h3;
            writeStrobe_reg <= 2'h3;
        end else begin
            readStrobeN_reg <= ~readHit;
            writeStrobe_reg <= writeHit ^ ~controlA_reg.writePolarity;
        end
    end

    // Open-drain lines: output level is always low, only the enable moves.
    wire logic readType = state_reg == ST_READ &
        (isRead1 | isRead2 | isReadA);
    assign transferTypeANOut = 1'b0;
    assign transferTypeBNOut = 1'b0;
    assign skipOrIrqNOut = 1'b0;
    assign transferTypeANOe = readType | state_reg == ST_VECTOR;
    assign transferTypeBNOe = state_reg == ST_VECTOR;
    assign skipOrIrqNOe = skipPull | irqPull;

    // Chain passes priority only when this device has nothing pending.
    assign priorityChainOut = priorityChainIn & ~anyPending;
    assign flagBits = controlA_reg.flagBits;
    assign dxOut = dxOut_reg;
    assign dxOe = dxOe_reg;
    assign readStrobeN = readStrobeN_reg;
    assign writeStrobe = writeStrobe_reg;

    property p_read_strobe;
        @(posedge clock) disable iff (!nrst)
        (readStart && isRead1) |=> !readStrobeN[0];
    endproperty
    a_read_strobe: assert property (p_read_strobe)
        else $error("read strobe missing");

    property p_write_pol;
        @(posedge clock) disable iff (!nrst)
        (state_reg == ST_IDLE && state_next != ST_WRITE)
            |=> writeStrobe == ~$past(controlA_reg.writePolarity);
    endproperty
    a_write_pol: assert property (p_write_pol)
        else $error("write strobe idle level wrong");

    property p_vector_type;
        @(posedge clock) disable iff (!nrst)
        vectorWin && state_reg == ST_IDLE
            |=> transferTypeANOe && transferTypeBNOe && dxOe &&
            dxOut == $past(vectorWord);
    endproperty
    a_vector_type: assert property (p_vector_type)
        else $error("vector transfer lines wrong");

    property p_irq_pull;
        @(posedge clock) disable iff (!nrst)
        (cpu.loadAddressPulse && !irqGrant && |irqFlags) |-> skipOrIrqNOe;
    endproperty
    a_irq_pull: assert property (p_irq_pull)
        else $error("interrupt not requested");

    property p_flags;
        @(posedge clock) disable iff (!nrst)
        (writeStart && isWriteA) |=> flagBits == $past(dxIn[3:0]);
    endproperty
    a_flags: assert property (p_flags)
        else $error("flag outputs do not follow write");

    property p_freeze;
        @(posedge clock) disable iff (!nrst)
        irqGrant && !vectorDone |=> $stable(pending_reg);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("chain changed during grant");

    property p_chain_low;
        @(posedge clock) disable iff (!nrst)
        !priorityChainIn && state_reg == ST_IDLE |=> !transferTypeBNOe;
    endproperty
    a_chain_low: assert property (p_chain_low)
        else $error("vector without chain priority");

    property p_caf;
        @(posedge clock) disable iff (!nrst)
        clearAllFlagsCmd && $past(nrst) &&
            controlB_reg.senseLevelSelect == 4'h0 && $stable(sense)
            |=> skipFlags == 4'h0 && irqFlags == 4'h0;
    endproperty
    a_caf: assert property (p_caf)
        else $error("clear all left a flag set");

    c_vector: cover property (@(posedge clock) disable iff (!nrst)
        vectorDone);
    c_skip: cover property (@(posedge clock) disable iff (!nrst)
        readDone && isSkip && skipPull);
    c_read_a: cover property (@(posedge clock) disable iff (!nrst)
        dxOe && isReadA);

endmodule

// ==== verification/pis_cpu_model.sv ====
`timescale 1ns/1ns
// Processor side: issues I/O instructions and watches the open-drain lines.
module pis_cpu_model
    import pis_pkg::*;
(
    input wire logic clock,
    output pis_cpu_t cpu,
    output logic addressMatch,
    output logic irqGrant,
    output logic [DATA_BITS-1:0] dxIn,
    input wire logic [DATA_BITS-1:0] dxOut,
    input wire logic dxOe,
    input wire logic typeALine,
    input wire logic typeBLine,
    input wire logic skipLine
);
    // Idle bus at time zero; select is high, so nothing is requested.
    initial begin
        cpu = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
        addressMatch = 1'b1;
        irqGrant = 1'b0;
        dxIn = 12'h5a5;
    end

    // One instruction: load pulse, one select window, then a gap cycle.
    // Lines return as {irq, typeA, typeB, skip}, a one meaning pulled low.
    // Released data lines are inverted, so a stale value never passes.
    task automatic io_instruction(input logic [3:0] cmd, input logic [11:0] data,
        input logic rd, input logic gnt, output logic [11:0] word,
        output logic [3:0] lines);
        @(posedge clock);
        cpu.loadAddressPulse <= 1'b1;
        cpu.ioInstruction <= 1'b1;
        dxIn <= {8'h00, cmd};
        #1 lines[3] = !skipLine;
        @(posedge clock);
        cpu.loadAddressPulse <= 1'b0;
        cpu.deviceSelectN <= 1'b0;
        cpu.ioExecutePhase <= 1'b1;
        cpu.readWriteTiming <= rd;
        irqGrant <= gnt;
        dxIn <= rd ? ~dxIn : data;
        repeat (2) @(posedge clock);
        #1 word = dxOe ? dxOut : 12'h000;
        lines[2:0] = {!typeALine, !typeBLine, !skipLine};
        @(posedge clock);
        cpu.deviceSelectN <= 1'b1;
        cpu.ioExecutePhase <= 1'b0;
        cpu.ioInstruction <= 1'b0;
        cpu.readWriteTiming <= 1'b0;
        irqGrant <= 1'b0;
        dxIn <= ~dxIn;
        @(posedge clock);
    endtask
endmodule

// ==== verification/pis_parallel_io_tb_top.sv ====
`timescale 1ns/1ns
module pis_parallel_io_tb_top
    import pis_pkg::*;
();
    logic clock, nrst, clearAllFlagsCmd, priorityChainIn, priorityChainOut;
    logic [3:0] sense, flagBits, lines;
    pis_cpu_t cpu;
    logic addressMatch, irqGrant, dxOe, aOut, aOe, bOut, bOe, sOut, sOe;
    logic [11:0] dxIn, dxOut, word;
    logic [1:0] readStrobeN, writeStrobe;
    wire logic aLine = !(aOe && !aOut);
    wire logic bLine = !(bOe && !bOut);
    wire logic sLine = !(sOe && !sOut);
    int miscompares, num_checks, cycles, i;
    logic [3:0] sc [4] = '{CMD_READ1, CMD_READ2, CMD_WRITE1, CMD_WRITE2};
    logic [3:0] sx [4] = '{4'ha, 4'h6, 4'hf, 4'hc};
    logic [3:0] kc [4] = '{CMD_SKIP1, CMD_SKIP2, CMD_SKIP3, CMD_SKIP4};

    pis_parallel_io pis_parallel_io_i (.clock(clock), .nrst(nrst),
        .cpu(cpu), .addressMatch(addressMatch),
        .clearAllFlagsCmd(clearAllFlagsCmd), .irqGrant(irqGrant),
        .priorityChainIn(priorityChainIn),
        .priorityChainOut(priorityChainOut), .dxIn(dxIn), .dxOut(dxOut),
        .dxOe(dxOe), .sense(sense), .flagBits(flagBits),
        .readStrobeN(readStrobeN), .writeStrobe(writeStrobe),
        .transferTypeANIn(aLine), .transferTypeANOut(aOut),
        .transferTypeANOe(aOe), .transferTypeBNIn(bLine),
        .transferTypeBNOut(bOut), .transferTypeBNOe(bOe),
        .skipOrIrqNIn(sLine), .skipOrIrqNOut(sOut), .skipOrIrqNOe(sOe));

    pis_cpu_model pis_cpu_model_i (.clock(clock), .cpu(cpu),
        .addressMatch(addressMatch), .irqGrant(irqGrant), .dxIn(dxIn),
        .dxOut(dxOut), .dxOe(dxOe), .typeALine(aLine), .typeBLine(bLine),
        .skipLine(sLine));

    // Free-running clock at 100 ns.
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // A hang is cut short well beyond the few hundred cycles needed.
    initial begin
        cycles = 0;
        forever begin
            @(posedge clock);
            cycles++;
            if (cycles > 2000) begin
                miscompares++;
                close_out();
            end
        end
    end

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] cmd, input logic [11:0] data);
        logic [11:0] w;
        logic [3:0] l;
        pis_cpu_model_i.io_instruction(cmd, data, 1'b0, 1'b0, w, l);
    endtask

    task automatic rd(input logic [3:0] cmd, input logic gnt);
        pis_cpu_model_i.io_instruction(cmd, 12'h000, 1'b1, gnt, word, lines);
    endtask

    // Raise a sense pattern and let the edge reach the sense flops.
    task automatic drive_sense(input logic [3:0] v);
        @(posedge clock) sense <= v;
        repeat (3) @(posedge clock);
    endtask

    task automatic close_out();
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence of instructions with expected results.
    initial begin
        miscompares = 0;
        num_checks = 0;
        nrst = 1'b0;
        clearAllFlagsCmd = 1'b0;
        priorityChainIn = 1'b1;
        sense = 4'h0;
        repeat (10) @(posedge clock);
        chk({6'h00, readStrobeN, writeStrobe, flagBits[1:0]}, 12'h03c);
        nrst <= 1'b1;
        wr(CMD_WR_CTRL_A, 12'h105);
        chk({8'h00, flagBits}, 12'h005);
        rd(CMD_RD_CTRL_A, 1'b0);
        chk(word, 12'h105);
        chk({8'h00, lines}, 12'h004);
        wr(CMD_CLR_FLAG1, 12'h000);
        chk({8'h00, flagBits}, 12'h004);
        // Read and write strobes sampled while the window stands.
        for (i = 0; i < 4; i++) begin
            fork
                pis_cpu_model_i.io_instruction(sc[i], 12'h0a5, i < 2, 1'b0, word,
                    lines);
                begin
                    repeat (4) @(posedge clock);
                    #2 chk({8'h00, readStrobeN, writeStrobe},
                        {8'h00, sx[i]});
                end
            join
            if (i > 1) chk({8'h00, lines}, 12'h000);
        end
        // Rising edges set each skip flop once; the skip clears it.
        wr(CMD_WR_CTRL_B, 12'h0f0);
        drive_sense(4'hf);
        for (i = 0; i < 4; i++) begin
            rd(kc[i], 1'b0);
            chk({8'h00, lines}, 12'h001);
            rd(kc[i], 1'b0);
            chk({8'h00, lines}, 12'h000);
        end
        // Low level sets the flop again after every skip.
        wr(CMD_WR_CTRL_B, 12'h00f);
        drive_sense(4'h0);
        rd(CMD_SKIP1, 1'b0);
        rd(CMD_SKIP1, 1'b0);
        chk({8'h00, lines}, 12'h001);
        // Enabled level events must still never raise an interrupt.
        wr(CMD_WR_CTRL_A, 12'h0f0);
        rd(CMD_RD_CTRL_A, 1'b0);
        chk({11'h000, lines[3]}, 12'h000);
        wr(CMD_WR_CTRL_B, 12'h0f0);
        @(posedge clock) clearAllFlagsCmd <= 1'b1;
        @(posedge clock) clearAllFlagsCmd <= 1'b0;
        rd(CMD_SKIP1, 1'b0);
        chk({8'h00, lines}, 12'h000);
        // Enabled edge requests on senses three and four, then vectors.
        wr(CMD_WR_CTRL_A, 12'h0c0);
        wr(CMD_WR_VECTOR, 12'h155);
        drive_sense(4'hf);
        rd(CMD_RD_CTRL_A, 1'b0);
        chk({11'h000, lines[3]}, 12'h001);
        chk({11'h000, priorityChainOut}, 12'h000);
        rd(CMD_READ1, 1'b1);
        chk(word, 12'h955);
        chk({10'h000, lines[2:1]}, 12'h003);
        rd(CMD_READ1, 1'b1);
        chk(word, 12'hd55);
        rd(CMD_RD_CTRL_A, 1'b0);
        chk({11'h000, lines[3]}, 12'h000);
        // With the chain input low the block gives no vector.
        drive_sense(4'h0);
        drive_sense(4'hf);
        @(posedge clock) priorityChainIn <= 1'b0;
        rd(CMD_READ1, 1'b1);
        chk(word, 12'h000);
        chk({10'h000, lines[2:1]}, 12'h000);
        close_out();
    end
endmodule
